/* File: cdv_board.sv */
// Purpose: free-running source clock
// Assumes: phase of 6 clk_in cycles
// Notes: slow enough for the sampler
module cdv_board (
  input  wire logic clk_in,
  output logic      src_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase_cnt = 0;
  initial src_clock_out = 1'h0;
  always @(negedge clk_in) begin
    phase_cnt = (phase_cnt + 1) % 6;
    if (phase_cnt == 0) src_clock_out <= ~src_clock_out;
  end
endmodule // cdv_board

/* File: cdv_divider.sv */
// Purpose: divide-by-2/4/8 of a sampled source clock with hold and master reset
// Assumes: source clock well below half of clk_in; all pins but rstn_in are asynchronous
// Notes:   edges of the source clock are found by oversampling after two flops

// Contract
// - reset released while source clock high: outputs move on first following rise.
// - reset released while source clock low: outputs move on second following rise.
// - hold request takes effect at the first falling source edge after it.
// - while held, every divider stage keeps its present count.
// - releasing hold lets dividers continue from the held count.
// - after hold, outputs keep the same sequence and mutual relationship.
// - hold starts or stops only while the source clock is low.
// - dividers start at zero under rstn_in; board pulses master reset to align them.
module cdv_divider
  import cdv_pkg::*;
#(
  parameter int DIV_STAGES = CDV_DIV_STAGES
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic src_clock_in,
  input  wire logic div_enable_n_in,
  input  wire logic divider_sync_reset_in,
  output logic      half_rate_out,
  output logic      quarter_rate_out,
  output logic      eighth_rate_out
);
  import cdv_pkg::*;

  // synchronised pin levels
  logic [2:0]            pins_sync;
  logic                  src_level;
  logic                  enable_n;
  logic                  master_reset;

  // source edge detector
  logic                  level_reg;
  logic                  level_next;
  logic                  rise;
  logic                  fall;

  // hold control
  logic                  hold_reg;
  logic                  hold_next;

  // one rise to skip after a release seen with the source low
  logic                  skip_reg;
  logic                  skip_next;

  // divider stages
  logic                  count_rise;
  logic [DIV_STAGES-1:0] carry;
  logic [DIV_STAGES-1:0] count_bits;

  // the output pins are wired for exactly three stages
  if (DIV_STAGES != CDV_DIV_STAGES) begin : g_stage_check
    $error("cdv_divider: only three stages are served");
  end

  // pins are asynchronous to clk_in
  cdv_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in ({src_clock_in, div_enable_n_in, divider_sync_reset_in}),
    .sync_out (pins_sync)
  );

  assign src_level    = pins_sync[2];
  assign enable_n     = pins_sync[1];
  assign master_reset = pins_sync[0];

  // previous level, taken after both synchroniser flops
  always_comb begin
    level_next = src_level;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      level_reg <= CDV_LEVEL_RST;
    end else begin
      level_reg <= level_next;
    end
  end

  assign rise = src_level & ~level_reg;
  assign fall = ~src_level & level_reg;

  // hold moves only on a fall, so the gated stage clock is already low
  always_comb begin
    hold_next = hold_reg;
    if (fall) begin
      hold_next = enable_n;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hold_reg <= CDV_HOLD_RST;
    end else begin
      hold_reg <= hold_next;
    end
  end

  // a low level at release costs one extra rise
  always_comb begin
    skip_next = skip_reg;
    if (master_reset) begin
      skip_next = ~src_level;
    end else if (rise) begin
      skip_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      skip_reg <= CDV_SKIP_RST;
    end else begin
      skip_reg <= skip_next;
    end
  end

  // a held rise is dropped, not queued, so counting resumes where it stopped
  assign count_rise = rise & ~skip_reg & ~hold_reg & ~master_reset;

  // synchronous binary stages: common edges line up by construction
  for (genvar stage = 0; stage < DIV_STAGES; stage++) begin : g_stage
    logic bit_reg;
    logic bit_next;

    if (stage == 0) begin : g_first
      assign carry[stage] = count_rise;
    end else begin : g_upper
      assign carry[stage] = carry[stage-1] & count_bits[stage-1];
    end

    always_comb begin
      bit_next = bit_reg;
      if (master_reset) begin
        bit_next = CDV_COUNT_RST[stage];
      end else if (carry[stage]) begin
        bit_next = ~bit_reg;
      end
    end

    always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
        bit_reg <= CDV_COUNT_RST[stage];
      end else begin
        bit_reg <= bit_next;
      end
    end

    assign count_bits[stage] = bit_reg;
  end

  assign half_rate_out    = count_bits[CDV_HALF_BIT];
  assign quarter_rate_out = count_bits[CDV_QUARTER_BIT];
  assign eighth_rate_out  = count_bits[CDV_EIGHTH_BIT];
endmodule // cdv_divider

/* File: cdv_divider_bench.sv */
// Purpose: bench for cdv_divider
// Assumes: cdv_board source
// Notes: counts known from start
module cdv_divider_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rstn_in = 0, en_n = 0, sync_reset = 1;
  logic src;
  logic [2:0] q;
  int fails = 0, check_count = 0, cyc = 0;
  always #2 clk_in = ~clk_in;
  // about 200 cycles expected; the ceiling leaves a wide margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end
  cdv_board u_cdv_board (.clk_in(clk_in), .src_clock_out(src));
  cdv_divider u_cdv_divider (.clk_in(clk_in), .rstn_in(rstn_in), .src_clock_in(src),
    .div_enable_n_in(en_n), .divider_sync_reset_in(sync_reset), .half_rate_out(q[0]),
    .quarter_rate_out(q[1]), .eighth_rate_out(q[2]));
  task automatic check(logic [2:0] seen, logic [2:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t count %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rise(int n);
    repeat (n) @(posedge src);
    repeat (5) @(negedge clk_in);
  endtask
  // release one cycle into a phase, so the sampled level is unambiguous
  task automatic t_release(logic lvl);
    @(negedge clk_in);
    sync_reset = 1;
    repeat (4) @(negedge clk_in);
    check(q, 3'h0);
    wait (src == !lvl);
    wait (src == lvl);
    @(negedge clk_in);
    sync_reset = 0;
    rise(1);
    check(q, {2'h0, lvl});
    rise(1);
    check(q, lvl ? 3'h2 : 3'h1);
  endtask
  task automatic t_hold();
    wait (!src);
    @(negedge clk_in);
    en_n = 1;
    rise(3);
    check(q, 3'h2);
    wait (!src);
    @(negedge clk_in);
    en_n = 0;
    rise(2);
    check(q, 3'h3);
    rise(5);
    check(q, 3'h0);
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    rstn_in = 1;
    t_release(1'h1);
    t_release(1'h0);
    t_hold();
    end_of_test();
  end
endmodule // cdv_divider_bench

/* File: cdv_divider_checker.sv */
// Purpose: port checks for cdv_divider
// Assumes: source phases of 6 clk_in cycles
// Notes: hold window sized for that rate
module cdv_divider_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic src_clock_in,
  input wire logic div_enable_n_in,
  input wire logic divider_sync_reset_in,
  input wire logic half_rate_out,
  input wire logic quarter_rate_out,
  input wire logic eighth_rate_out
);
  logic [2:0] c;
  assign c = {eighth_rate_out, quarter_rate_out, half_rate_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_held; div_enable_n_in[*8] ##1 div_enable_n_in[*8]; endsequence
  // long reset released with the source sampled low; phases of 6 leave 11 idle cycles
  sequence s_low_release;
    divider_sync_reset_in[*4] ##1 (!divider_sync_reset_in && !$past(src_clock_in));
  endsequence
  sequence s_still_clear; (c == 3'h0)[*8] ##1 (c == 3'h0)[*3]; endsequence
  property p_clear; divider_sync_reset_in[*4] |-> c == 3'h0; endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");
  property p_skip; s_low_release |-> s_still_clear; endproperty
  a_skip: assert property (p_skip) else $error("skipped rise was counted");
  property p_step; $changed(c) && c != 3'h0 |-> c == $past(c) + 3'h1; endproperty
  a_step: assert property (p_step) else $error("count skipped");
  property p_rise;
    $changed(c) && c != 3'h0 |-> $past(src_clock_in, 3) && !$past(src_clock_in, 6);
  endproperty
  a_rise: assert property (p_rise) else $error("step without rise");
  property p_hold; s_held |-> $stable(c); endproperty
  a_hold: assert property (p_hold) else $error("count moved in hold");
  property p_wrap; $changed(c) && c == 3'h0 |->
    $past(c) == 3'h7 || $past(divider_sync_reset_in) || $past(divider_sync_reset_in, 3);
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad clear");
endmodule // cdv_divider_checker
bind cdv_divider cdv_divider_checker u_cdv_divider_checker (.clk_in(clk_in),
  .rstn_in(rstn_in), .src_clock_in(src_clock_in), .div_enable_n_in(div_enable_n_in),
  .divider_sync_reset_in(divider_sync_reset_in), .half_rate_out(half_rate_out),
  .quarter_rate_out(quarter_rate_out), .eighth_rate_out(eighth_rate_out));

/* File: cdv_sync.sv */
// Purpose: shared constants and the two-stage input synchroniser
// Assumes: single clock clk_in, synchronous active-low reset
// Notes:   first stage feeds only the second stage
package cdv_pkg;
  localparam int          CDV_SYNC_STAGES   = 2;
  localparam int          CDV_DIV_STAGES    = 3;
  localparam logic [2:0]  CDV_COUNT_RST     = 3'h0;
  localparam logic        CDV_HOLD_RST      = 1'h0;
  localparam logic        CDV_SKIP_RST      = 1'h1;
  localparam logic        CDV_LEVEL_RST     = 1'h0;
  localparam int          CDV_HALF_BIT      = 0;
  localparam int          CDV_QUARTER_BIT   = 1;
  localparam int          CDV_EIGHTH_BIT    = 2;
endpackage : cdv_pkg

module cdv_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import cdv_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // refused at elaboration, before any logic is built
  if (WIDTH < 1) begin : g_width_check
    $error("cdv_sync: WIDTH must be at least 1");
  end

  always_comb begin
    meta_next   = async_in;
    stable_next = meta_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
    end
  end

  assign sync_out = stable_reg;
endmodule // cdv_sync
